// >>> logic/pamp_regs.sv
// Per-port register bank: table access control, mirroring, ingress priority.
// Assumes an AXI4-Lite master and switch fabric strobes on the same clock.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module pamp_regs (
  // Clock and reset
  input  wire logic                                             clk,
  input  wire logic                                             rst,
  // AXI4-Lite register bus
  input  wire pamp_pkg::pamp_axi_m2s_t                          axi_i,
  output pamp_pkg::pamp_axi_s2m_t                               axi_o,
  // Switch fabric, one entry per port
  input  wire pamp_pkg::pamp_port_in_t [pamp_pkg::NUM_PORTS-1:0] sw_i,
  output pamp_pkg::pamp_port_out_t [pamp_pkg::NUM_PORTS-1:0]    sw_o
);
  import pamp_pkg::*;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic                                aw_full;
    logic [ADDR_W-1:0]                   aw_addr;
    logic                                w_full;
    logic [7:0]                          w_data;
    logic                                w_lane0;
    pamp_axi_s2m_t                       bus;
    logic [NUM_PORTS-1:0][7:0]           be_msb;
    logic [NUM_PORTS-1:0][7:0]           be_lsb;
    logic [NUM_PORTS-1:0][7:0]           acl_ctrl;
    logic [NUM_PORTS-1:0][7:0]           mirror;
    logic [NUM_PORTS-1:0][7:0]           prio_ctrl;
    pamp_port_out_t [NUM_PORTS-1:0]      out;
  } pamp_top_st_t;

  pamp_top_st_t s_r;
  pamp_top_st_t s_nxt;

  logic                                  wr_fire;
  logic [13:0]                           wr_idx;
  logic [1:0]                            wr_port;
  logic [11:0]                           wr_sub;
  logic                                  wr_hit;
  logic [13:0]                           rd_idx;
  logic [1:0]                            rd_port;
  logic [11:0]                           rd_sub;
  logic                                  rd_hit;
  logic [7:0]                            rd_val;
  logic                                  any_mon;
  logic [NUM_PORTS-1:0]                  eng_launch;
  logic [NUM_PORTS-1:0]                  eng_stage_we;
  logic [NUM_PORTS-1:0]                  eng_wr_done;
  logic [NUM_PORTS-1:0]                  eng_rd_done;
  logic [NUM_PORTS-1:0][ACL_BYTES-1:0][7:0] eng_stage;
  logic [NUM_PORTS-1:0][2:0]             prio_c;

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------
  // Port field 0 is not a port page, so it decodes as unmapped
  function automatic logic pamp_mapped(input logic [13:0] idx);
    logic [11:0] sub;
    sub = idx[11:0];
    return (idx[13:12] >= PORT_FIRST) &&
           (((sub >= IDX_ACL_DATA_FIRST) && (sub <= IDX_ACL_CTRL)) ||
            (sub == IDX_MIRROR) || (sub == IDX_PRIO));
  endfunction : pamp_mapped

  assign wr_idx  = s_r.aw_addr[ADDR_W-1:2];
  assign wr_port = wr_idx[13:12];
  assign wr_sub  = wr_idx[11:0];
  assign wr_hit  = pamp_mapped(wr_idx);
  assign rd_idx  = axi_i.araddr[ADDR_W-1:2];
  assign rd_port = rd_idx[13:12];
  assign rd_sub  = rd_idx[11:0];
  assign rd_hit  = pamp_mapped(rd_idx);

  // A write is performed once address and data are both held and the
  // previous response has been taken
  assign wr_fire = s_r.aw_full && s_r.w_full && !s_r.bus.bvalid;

  // ---------------------------------------------------------------------
  // Table engine requests
  // ---------------------------------------------------------------------
  always_comb
  begin
    eng_launch   = '0;
    eng_stage_we = '0;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (wr_fire && wr_hit && s_r.w_lane0 && (wr_port == 2'(p + 1)))
      begin
        eng_launch[p]   = (wr_sub == IDX_BE_LSB);
        eng_stage_we[p] = (wr_sub <= IDX_ACL_DATA_LAST);
      end
    end
  end

  // ---------------------------------------------------------------------
  // Read data mux
  // ---------------------------------------------------------------------
  // Reserved bits come back as zero because only writable bits are stored
  always_comb
  begin
    rd_val = 8'h00;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (rd_hit && (rd_port == 2'(p + 1)))
      begin
        if (rd_sub <= IDX_ACL_DATA_LAST)
          rd_val = eng_stage[p][rd_sub[3:0]];
        case (rd_sub)
          IDX_BE_MSB:
            rd_val = s_r.be_msb[p];
          IDX_BE_LSB:
            rd_val = s_r.be_lsb[p];
          IDX_ACL_CTRL:
          begin
            rd_val                  = s_r.acl_ctrl[p];
            rd_val[ACL_WR_DONE_BIT] = eng_wr_done[p];
            rd_val[ACL_RD_DONE_BIT] = eng_rd_done[p];
          end
          IDX_MIRROR:
            rd_val = s_r.mirror[p];
          IDX_PRIO:
            rd_val = s_r.prio_ctrl[p];
          default:
            ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    // Address and data are taken independently, in either order
    if (axi_i.awvalid && s_r.bus.awready)
    begin
      s_nxt.aw_full = 1'b1;
      s_nxt.aw_addr = axi_i.awaddr;
    end
    if (axi_i.wvalid && s_r.bus.wready)
    begin
      s_nxt.w_full  = 1'b1;
      s_nxt.w_data  = axi_i.wdata[7:0];
      s_nxt.w_lane0 = axi_i.wstrb[0];
    end
    if (s_r.bus.bvalid && axi_i.bready)
      s_nxt.bus.bvalid = 1'b0;
    if (wr_fire)
    begin
      s_nxt.aw_full    = 1'b0;
      s_nxt.w_full     = 1'b0;
      s_nxt.bus.bvalid = 1'b1;
      s_nxt.bus.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
      // Data sit in byte lane 0; a write without that lane changes nothing
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        if (wr_hit && s_r.w_lane0 && (wr_port == 2'(p + 1)))
        begin
          case (wr_sub)
            IDX_BE_MSB:
              s_nxt.be_msb[p] = s_r.w_data;
            IDX_BE_LSB:
              s_nxt.be_lsb[p] = s_r.w_data;
            IDX_ACL_CTRL:
              s_nxt.acl_ctrl[p] = s_r.w_data & ACL_CTRL_WMASK;
            IDX_MIRROR:
              s_nxt.mirror[p] = s_r.w_data & MIR_WMASK;
            IDX_PRIO:
              s_nxt.prio_ctrl[p] = s_r.w_data & PRI_WMASK;
            default:
              ;
          endcase
        end
      end
    end
    // Holding off new writes until the response is taken keeps one in flight
    s_nxt.bus.awready = !s_nxt.aw_full && !s_nxt.bus.bvalid;
    s_nxt.bus.wready  = !s_nxt.w_full && !s_nxt.bus.bvalid;

    if (s_r.bus.rvalid && axi_i.rready)
      s_nxt.bus.rvalid = 1'b0;
    if (axi_i.arvalid && s_r.bus.arready)
    begin
      s_nxt.bus.rvalid = 1'b1;
      s_nxt.bus.rdata  = {{(DATA_W - 8){1'b0}}, rd_val};
      s_nxt.bus.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    s_nxt.bus.arready = !s_nxt.bus.rvalid;

    // Mirroring and priority outputs, registered one cycle behind the fabric
    any_mon = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      s_nxt.out[p].rx_mon  = sw_i[p].rx_pkt & s_r.mirror[p][MIR_RX_BIT];
      s_nxt.out[p].tx_mon  = sw_i[p].tx_pkt & s_r.mirror[p][MIR_TX_BIT];
      s_nxt.out[p].sniffer = s_r.mirror[p][MIR_SNIFFER_BIT];
      s_nxt.out[p].prio    = prio_c[p];
      any_mon = any_mon | s_nxt.out[p].rx_mon | s_nxt.out[p].tx_mon;
    end
    for (int p = 0; p < NUM_PORTS; p++)
      s_nxt.out[p].sniff_tx = s_nxt.out[p].sniffer & any_mon;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign axi_o = s_r.bus;
  assign sw_o  = s_r.out;

  // ---------------------------------------------------------------------
  // Bus protocol checks
  // ---------------------------------------------------------------------
  chk_bresp_hold: assert property (@(posedge clk) disable iff (rst)
    (axi_o.bvalid && !axi_i.bready) |=> axi_o.bvalid && $stable(axi_o.bresp))
    else $error("write response dropped before it was taken");
  chk_rdata_hold: assert property (@(posedge clk) disable iff (rst)
    (axi_o.rvalid && !axi_i.rready) |=> axi_o.rvalid && $stable(axi_o.rdata))
    else $error("read data changed before it was taken");
  chk_one_write: assert property (@(posedge clk) disable iff (rst)
    axi_o.bvalid |-> !axi_o.awready && !axi_o.wready)
    else $error("new write accepted while response pending");
  chk_one_read: assert property (@(posedge clk) disable iff (rst)
    axi_o.rvalid |-> !axi_o.arready)
    else $error("new read accepted while data pending");
  chk_unmapped_read: assert property (@(posedge clk) disable iff (rst)
    (axi_i.arvalid && axi_o.arready && !rd_hit)
    |=> (axi_o.rresp == RESP_SLVERR) && (axi_o.rdata == '0))
    else $error("unmapped read not refused with zero data");

  // ---------------------------------------------------------------------
  // Per-port engines and priority resolvers
  // ---------------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    pamp_acl_engine u_engine (
      .clk          (clk),
      .rst          (rst),
      .launch       (eng_launch[p]),
      .launch_write (s_r.acl_ctrl[p][ACL_DIR_BIT]),
      .launch_entry (s_r.acl_ctrl[p][3:0]),
      .launch_be    ({s_r.be_msb[p], s_r.w_data}),
      .stage_we     (eng_stage_we[p]),
      .stage_sel    (wr_sub[3:0]),
      .stage_wdata  (s_r.w_data),
      .stage_q      (eng_stage[p]),
      .wr_done      (eng_wr_done[p]),
      .rd_done      (eng_rd_done[p])
    );

    pamp_prio_sel u_prio (
      .ctrl      (s_r.prio_ctrl[p]),
      .cls_valid (sw_i[p].cls_valid),
      .cls_prio  (sw_i[p].cls_prio),
      .dflt_prio (sw_i[p].dflt_prio),
      .prio      (prio_c[p])
    );

    chk_dir_index_store: assert property (@(posedge clk) disable iff (rst)
      (wr_fire && wr_hit && s_r.w_lane0 && wr_port == 2'(p + 1) && wr_sub == IDX_ACL_CTRL)
      |=> s_r.acl_ctrl[p] == ($past(s_r.w_data) & ACL_CTRL_WMASK))
      else $error("direction or index field not stored");
    chk_rx_sniff_mark: assert property (@(posedge clk) disable iff (rst)
      sw_i[p].rx_pkt |=> sw_o[p].rx_mon == $past(s_r.mirror[p][MIR_RX_BIT]))
      else $error("receive monitoring does not follow sniff bit");
    chk_tx_sniff_mark: assert property (@(posedge clk) disable iff (rst)
      sw_i[p].tx_pkt |=> sw_o[p].tx_mon == $past(s_r.mirror[p][MIR_TX_BIT]))
      else $error("transmit monitoring does not follow sniff bit");
    chk_sniffer_follow: assert property (@(posedge clk) disable iff (rst)
      (wr_fire && wr_hit && s_r.w_lane0 && wr_port == 2'(p + 1) && wr_sub == IDX_MIRROR)
      |-> ##2 sw_o[p].sniffer == $past(s_r.w_data[MIR_SNIFFER_BIT], 2))
      else $error("sniffer output does not follow written bit");

    for (genvar i = 0; i < NUM_SRC; i++)
    begin : g_src
      chk_highest_bound: assert property (@(posedge clk) disable iff (rst)
        (s_r.prio_ctrl[p][PRI_HIGHEST_BIT] && s_r.prio_ctrl[p][i] && sw_i[p].cls_valid[i])
        |=> sw_o[p].prio >= $past(sw_i[p].cls_prio[i]))
        else $error("highest priority below an enabled source");
      chk_or_cover: assert property (@(posedge clk) disable iff (rst)
        (s_r.prio_ctrl[p][PRI_OR_BIT] && !s_r.prio_ctrl[p][PRI_HIGHEST_BIT] &&
         s_r.prio_ctrl[p][i] && sw_i[p].cls_valid[i])
        |=> (sw_o[p].prio & $past(sw_i[p].cls_prio[i])) == $past(sw_i[p].cls_prio[i]))
        else $error("combined priority misses a source bit");
      chk_single_source: assert property (@(posedge clk)
        disable iff (rst)
        (s_r.prio_ctrl[p] == 8'(1 << i) && sw_i[p].cls_valid[i])
        |=> sw_o[p].prio == $past(sw_i[p].cls_prio[i]))
        else $error("single enabled source not used");
    end
  end
endmodule : pamp_regs

// >>> logic/pamp_pkg.sv
// Constants, field layout and carrier types for the per-port table access,
// mirroring and ingress priority register bank.
// Assumes a 40 MHz system clock and one copy of each register per port.
package pamp_pkg;
  localparam int NUM_PORTS = 3;
  localparam int NUM_SRC   = 5;
  localparam int ACL_BYTES = 16;
  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 32;
  localparam int CLK_PERIOD_NS = 25;

  // Register indices inside one port page; byte address is 4 * {port, index}
  localparam logic [11:0] IDX_ACL_DATA_FIRST = 12'h600;
  localparam logic [11:0] IDX_ACL_DATA_LAST  = 12'h60f;
  localparam logic [11:0] IDX_BE_MSB         = 12'h610;
  localparam logic [11:0] IDX_BE_LSB         = 12'h611;
  localparam logic [11:0] IDX_ACL_CTRL       = 12'h612;
  localparam logic [11:0] IDX_MIRROR         = 12'h800;
  localparam logic [11:0] IDX_PRIO           = 12'h801;
  localparam logic [1:0]  PORT_FIRST         = 2'h1;

  // Field positions
  localparam int ACL_WR_DONE_BIT = 6;
  localparam int ACL_RD_DONE_BIT = 5;
  localparam int ACL_DIR_BIT     = 4;
  localparam int MIR_RX_BIT      = 6;
  localparam int MIR_TX_BIT      = 5;
  localparam int MIR_SNIFFER_BIT = 1;
  localparam int PRI_HIGHEST_BIT = 7;
  localparam int PRI_OR_BIT      = 6;
  localparam int PRI_MAC_BIT     = 4;
  localparam int PRI_VLAN_BIT    = 3;
  localparam int PRI_DOT1P_BIT   = 2;
  localparam int PRI_DSCP_BIT    = 1;
  localparam int PRI_ACL_BIT     = 0;

  // Writable masks and reset values
  localparam logic [7:0] ACL_CTRL_WMASK = 8'h1f;
  localparam logic [7:0] MIR_WMASK      = 8'h62;
  localparam logic [7:0] PRI_WMASK      = 8'hdf;
  localparam logic       DONE_RESET     = 1'b1;
  localparam logic [3:0] SLOT_LAST      = 4'hf;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b01,
    ENG_RUN  = 2'b10
  } pamp_eng_state_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } pamp_axi_m2s_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } pamp_axi_s2m_t;

  typedef struct packed {
    logic                      rx_pkt;
    logic                      tx_pkt;
    logic [NUM_SRC-1:0]        cls_valid;
    logic [NUM_SRC-1:0][2:0]   cls_prio;
    logic [2:0]                dflt_prio;
  } pamp_port_in_t;

  typedef struct packed {
    logic       rx_mon;
    logic       tx_mon;
    logic       sniffer;
    logic       sniff_tx;
    logic [2:0] prio;
  } pamp_port_out_t;
endpackage : pamp_pkg

// >>> logic/pamp_prio_sel.sv
// Ingress priority resolver for one port: picks among or ORs classified priorities.
// Assumes classifier results arrive on the same clock; purely combinational.
`timescale 1ns/1ps
module pamp_prio_sel (
  // Control byte and classifier results
  input  wire logic [7:0]                           ctrl,
  input  wire logic [pamp_pkg::NUM_SRC-1:0]         cls_valid,
  input  wire logic [pamp_pkg::NUM_SRC-1:0][2:0]    cls_prio,
  input  wire logic [2:0]                           dflt_prio,
  // Resolved priority
  output logic [2:0]                                prio
);
  import pamp_pkg::*;
  logic [NUM_SRC-1:0] en;
  assign en[PRI_MAC_BIT]   = ctrl[PRI_MAC_BIT] & cls_valid[PRI_MAC_BIT];
  assign en[PRI_VLAN_BIT]  = ctrl[PRI_VLAN_BIT] & cls_valid[PRI_VLAN_BIT];
  assign en[PRI_DOT1P_BIT] = ctrl[PRI_DOT1P_BIT] & cls_valid[PRI_DOT1P_BIT];
  assign en[PRI_DSCP_BIT]  = ctrl[PRI_DSCP_BIT] & cls_valid[PRI_DSCP_BIT];
  assign en[PRI_ACL_BIT]   = ctrl[PRI_ACL_BIT] & cls_valid[PRI_ACL_BIT];

  // Highest wins over OR when both are set; with neither set, the top enabled source
  always_comb
  begin
    logic [2:0] hi;
    logic [2:0] orv;
    logic [2:0] first;
    logic       found;
    hi    = 3'h0;
    orv   = 3'h0;
    first = dflt_prio;
    found = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (en[i])
      begin
        orv = orv | cls_prio[i];
        if (cls_prio[i] > hi)
          hi = cls_prio[i];
        if (!found)
          first = cls_prio[i];
        found = 1'b1;
      end
    end
    if (!found)
      prio = dflt_prio;
    else if (ctrl[PRI_HIGHEST_BIT])
      prio = hi;
    else if (ctrl[PRI_OR_BIT])
      prio = orv;
    else
      prio = first;
  end
endmodule : pamp_prio_sel

// >>> logic/pamp_acl_engine.sv
// Table engine for one port: staging bytes, 16-entry table, completion flags.
// Assumes launches come from the register bank on the same clock.
`timescale 1ns/1ps
module pamp_acl_engine (
  // Clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 rst,
  // Launch request
  input  wire logic                                 launch,
  input  wire logic                                 launch_write,
  input  wire logic [3:0]                           launch_entry,
  input  wire logic [15:0]                          launch_be,
  // Staging access
  input  wire logic                                 stage_we,
  input  wire logic [3:0]                           stage_sel,
  input  wire logic [7:0]                           stage_wdata,
  output logic [pamp_pkg::ACL_BYTES-1:0][7:0]       stage_q,
  // Status
  output logic                                      wr_done,
  output logic                                      rd_done
);
  import pamp_pkg::*;
  typedef struct packed {
    pamp_eng_state_t                    fsm;
    logic [3:0]                         slot;
    logic                               write;
    logic [3:0]                         entry;
    logic [15:0]                        be;
    logic                               wr_done;
    logic                               rd_done;
    logic [ACL_BYTES-1:0][7:0]          stage;
    logic [15:0][ACL_BYTES-1:0][7:0]    table_q;
  } pamp_eng_st_t;
  localparam pamp_eng_st_t ENG_RESET = '{fsm: ENG_IDLE, wr_done: DONE_RESET,
                                         rd_done: DONE_RESET, default: '0};
  pamp_eng_st_t s_r;
  pamp_eng_st_t s_nxt;

  // One byte slot per cycle; enable bit b selects staging byte 15-b
  always_comb
  begin
    s_nxt = s_r;
    if (stage_we)
      s_nxt.stage[stage_sel] = stage_wdata;
    case (s_r.fsm)
      ENG_IDLE:
      begin
        if (launch)
        begin
          s_nxt.fsm   = ENG_RUN;
          s_nxt.slot  = 4'h0;
          s_nxt.write = launch_write;
          s_nxt.entry = launch_entry;
          s_nxt.be    = launch_be;
          if (launch_write)
            s_nxt.wr_done = 1'b0;
          else
            s_nxt.rd_done = 1'b0;
        end
      end
      ENG_RUN:
      begin
        if (s_r.be[~s_r.slot])
        begin
          if (s_r.write)
            s_nxt.table_q[s_r.entry][s_r.slot] = s_r.stage[s_r.slot];
          else
            s_nxt.stage[s_r.slot] = s_r.table_q[s_r.entry][s_r.slot];
        end
        if (s_r.slot == SLOT_LAST)
        begin
          s_nxt.fsm = ENG_IDLE;
          if (s_r.write)
            s_nxt.wr_done = 1'b1;
          else
            s_nxt.rd_done = 1'b1;
        end
        else
          s_nxt.slot = s_r.slot + 4'h1;
      end
      default:
        s_nxt.fsm = ENG_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_r <= ENG_RESET;
    else
      s_r <= s_nxt;
  end

  assign stage_q = s_r.stage;
  assign wr_done = s_r.wr_done;
  assign rd_done = s_r.rd_done;

  chk_write_flag_cycle: assert property (@(posedge clk) disable iff (rst)
    (launch && launch_write && s_r.fsm == ENG_IDLE) |=> !wr_done ##16 wr_done)
    else $error("write flag not cleared then set after 16 slots");
  chk_read_flag_cycle: assert property (@(posedge clk) disable iff (rst)
    (launch && !launch_write && s_r.fsm == ENG_IDLE) |=> !rd_done ##16 rd_done)
    else $error("read flag not cleared then set after 16 slots");
  chk_launch_clears_flag: assert property (@(posedge clk) disable iff (rst)
    (launch && s_r.fsm == ENG_IDLE) |=> (s_r.write ? !wr_done : !rd_done) [*8])
    else $error("completion flag set again before transfer end");
  chk_run_needs_launch: assert property (@(posedge clk) disable iff (rst)
    (s_r.fsm == ENG_RUN && s_r.slot == 4'h0) |-> $past(launch))
    else $error("transfer started without a launch");
endmodule : pamp_acl_engine

// >>> tb/tb_pamp_regs.sv
// Bench for the per-port register bank: AXI4-Lite tasks and fabric strobes.
// Assumes pamp_pkg is compiled first; byte address is {port, index, 2'b00}.
`timescale 1ns/1ps
module tb_pamp_regs;
  import pamp_pkg::*;
  localparam logic [4:0][2:0] PE = {3'h6, 3'h5, 3'h4, 3'h2, 3'h1};
  logic                           clk;
  logic                           rst;
  pamp_axi_m2s_t                  m;
  pamp_axi_s2m_t                  s;
  pamp_port_in_t  [NUM_PORTS-1:0] sw;
  pamp_port_out_t [NUM_PORTS-1:0] so;
  int                             err_total;
  int                             total_checks;
  int                             cyc;
  logic [7:0]                     d;
  logic [1:0]                     r;

  pamp_regs pamp_regs_inst (.clk(clk), .rst(rst), .axi_i(m), .axi_o(s), .sw_i(sw), .sw_o(so));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Whole run needs a few hundred cycles; anything far beyond is a hang
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  function automatic logic [15:0] ba(input logic [1:0] p, input logic [11:0] i);
    return {p, i, 2'h0};
  endfunction : ba

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Handshakes are judged at the falling edge, where the flops are settled
  task automatic wr(input logic [15:0] a, input logic [7:0] v, input logic [1:0] er);
    logic aw;
    logic w;
    logic b;
    @(posedge clk);
    m.awvalid <= 1'b1;
    m.awaddr  <= a;
    m.wvalid  <= 1'b1;
    m.wdata   <= {24'h0, v};
    m.wstrb   <= 4'hf;
    m.bready  <= 1'b1;
    b = 1'b0;
    while (!b)
    begin
      @(negedge clk);
      aw = m.awvalid & s.awready;
      w  = m.wvalid & s.wready;
      b  = s.bvalid;
      r  = s.bresp;
      @(posedge clk);
      if (aw)
        m.awvalid <= 1'b0;
      if (w)
        m.wvalid <= 1'b0;
    end
    m.bready <= 1'b0;
    chk(8'(r), 8'(er));
  endtask : wr

  task automatic rd(input logic [15:0] a);
    logic ar;
    logic done;
    @(posedge clk);
    m.arvalid <= 1'b1;
    m.araddr  <= a;
    m.rready  <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(negedge clk);
      ar   = m.arvalid & s.arready;
      done = s.rvalid;
      d    = s.rdata[7:0];
      r    = s.rresp;
      @(posedge clk);
      if (ar)
        m.arvalid <= 1'b0;
    end
    m.rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
    rd(a);
    chk(d, e);
    chk(8'(r), 8'(er));
  endtask : rc

  task automatic poll(input int bitn);
    int n;
    n = 0;
    do
    begin
      rd(ba(2'h1, IDX_ACL_CTRL));
      n++;
    end
    while (d[bitn] !== 1'b1 && n < 40);
    chk(8'(d[bitn]), 8'h01);
    chk(8'(r), 8'(RESP_OKAY));
  endtask : poll

  task automatic ev(input logic [5:0] e);
    @(posedge clk);
    sw[0].rx_pkt <= 1'b1;
    sw[0].tx_pkt <= 1'b1;
    @(posedge clk);
    sw[0].rx_pkt <= 1'b0;
    sw[0].tx_pkt <= 1'b0;
    #1;
    chk(8'({so[0].rx_mon, so[0].tx_mon, so[1].sniff_tx, so[1].sniffer,
            so[0].sniff_tx, so[2].sniff_tx}), 8'(e));
  endtask : ev

  task automatic pc(input logic [7:0] v, input logic [2:0] e);
    wr(ba(2'h1, IDX_PRIO), v, RESP_OKAY);
    repeat (2) @(posedge clk);
    #1;
    chk(8'(so[0].prio), 8'(e));
    chk(8'({so[1].prio, so[2].prio}), 8'h00);
  endtask : pc

  task automatic stop_test();
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    m = '0;
    sw = '0;
    err_total = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int p = 1; p <= 3; p++)
    begin
      rc(ba(2'(p), IDX_ACL_CTRL), 8'h60, RESP_OKAY);
      rc(ba(2'(p), IDX_MIRROR), 8'h00, RESP_OKAY);
      rc(ba(2'(p), IDX_PRIO), 8'h00, RESP_OKAY);
    end
    wr(ba(2'h3, IDX_ACL_CTRL), 8'hff, RESP_OKAY);
    rc(ba(2'h3, IDX_ACL_CTRL), 8'h7f, RESP_OKAY);
    wr(ba(2'h3, IDX_MIRROR), 8'hff, RESP_OKAY);
    rc(ba(2'h3, IDX_MIRROR), 8'h62, RESP_OKAY);
    wr(ba(2'h3, IDX_MIRROR), 8'h00, RESP_OKAY);
    wr(ba(2'h3, IDX_PRIO), 8'hff, RESP_OKAY);
    rc(ba(2'h3, IDX_PRIO), 8'hdf, RESP_OKAY);
    wr(ba(2'h0, IDX_PRIO), 8'hff, RESP_SLVERR);
    rc(ba(2'h0, IDX_PRIO), 8'h00, RESP_SLVERR);
    // Table write of entry 3, then read it back through cleared staging bytes
    wr(ba(2'h1, IDX_ACL_CTRL), 8'h13, RESP_OKAY);
    wr(ba(2'h1, IDX_ACL_DATA_FIRST), 8'h3c, RESP_OKAY);
    wr(ba(2'h1, IDX_ACL_DATA_LAST), 8'ha5, RESP_OKAY);
    wr(ba(2'h1, IDX_BE_MSB), 8'h80, RESP_OKAY);
    wr(ba(2'h1, IDX_BE_LSB), 8'h01, RESP_OKAY);
    rc(ba(2'h1, IDX_ACL_CTRL), 8'h33, RESP_OKAY);
    poll(6);
    rc(ba(2'h1, IDX_ACL_CTRL), 8'h73, RESP_OKAY);
    wr(ba(2'h1, IDX_ACL_DATA_FIRST), 8'h00, RESP_OKAY);
    wr(ba(2'h1, IDX_ACL_DATA_LAST), 8'h00, RESP_OKAY);
    wr(ba(2'h1, IDX_ACL_CTRL), 8'h03, RESP_OKAY);
    wr(ba(2'h1, IDX_BE_LSB), 8'h01, RESP_OKAY);
    rc(ba(2'h1, IDX_ACL_CTRL), 8'h43, RESP_OKAY);
    poll(5);
    rc(ba(2'h1, IDX_ACL_DATA_LAST), 8'ha5, RESP_OKAY);
    rc(ba(2'h1, IDX_ACL_DATA_FIRST), 8'h3c, RESP_OKAY);
    // Mirroring: port 1 monitored, port 2 the sniffer
    wr(ba(2'h1, IDX_MIRROR), 8'h40, RESP_OKAY);
    wr(ba(2'h2, IDX_MIRROR), 8'h02, RESP_OKAY);
    ev(6'b101100);
    wr(ba(2'h1, IDX_MIRROR), 8'h20, RESP_OKAY);
    ev(6'b011100);
    wr(ba(2'h2, IDX_MIRROR), 8'h00, RESP_OKAY);
    ev(6'b010000);
    // Priority sources, one enable at a time, then the combining modes
    @(posedge clk);
    sw[0].cls_valid <= 5'h1f;
    sw[0].cls_prio  <= PE;
    sw[0].dflt_prio <= 3'h3;
    for (int b = 0; b < 5; b++)
      pc(8'(1 << b), PE[b]);
    pc(8'h9f, 3'h6);
    pc(8'h5f, 3'h7);
    pc(8'h00, 3'h3);
    stop_test();
  end
endmodule : tb_pamp_regs
